/* boot_lock_pkg.sv */
package boot_lock_pkg;
  // ---------------------------------------------------------------
  // special function register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] AUX_ADDR = 8'h00a2;
  localparam logic [7:0] DPH_ADDR = 8'h0083;
  localparam logic [7:0] DPL_ADDR = 8'h0084;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int AUX_DPS_BIT   = 0;
  localparam int AUX_FLAG_BIT  = 3;
  localparam int AUX_BOOT_BIT  = 5;
  localparam int HSB_SPEED_BIT = 7;
  localparam int HSB_JUMP_BIT  = 6;
  localparam int HSB_LB2_BIT   = 2;
  localparam int HSB_LB1_BIT   = 1;
  localparam int HSB_LB0_BIT   = 0;
  localparam logic [7:0] HSB_RSV_MASK = 8'h0038;
  localparam logic [7:0] HSB_SW_MASK  = 8'h00c0;
  // ---------------------------------------------------------------
  // reset and erase values
  // ---------------------------------------------------------------
  localparam logic [7:0]  ERASED_BYTE  = 8'h00ff;
  localparam logic [7:0]  ZERO_BYTE    = 8'h0000;
  localparam logic [15:0] ZERO_WORD    = 16'h0000;
  localparam logic [15:0] BOOT_BASE    = 16'hf000;
  localparam logic [15:0] USER_VECTOR  = 16'h0000;
  // ---------------------------------------------------------------
  // protection levels and machine cycle lengths
  // ---------------------------------------------------------------
  localparam logic [1:0] LEVEL_0 = 2'h0;
  localparam logic [1:0] LEVEL_1 = 2'h1;
  localparam logic [1:0] LEVEL_2 = 2'h2;
  localparam logic [1:0] LEVEL_3 = 2'h3;
  localparam logic [3:0] CYC_STD = 4'h000c;
  localparam logic [3:0] CYC_X2  = 4'h0006;
  // ---------------------------------------------------------------
  // nonvolatile byte select and hardware mode commands
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_HSB = 2'h0;
  localparam logic [1:0] SEL_SBV = 2'h1;
  localparam logic [1:0] SEL_SSB = 2'h2;
  localparam logic [2:0] CMD_PROG_MEM   = 3'h1;
  localparam logic [2:0] CMD_VERIFY_MEM = 3'h2;
  localparam logic [2:0] CMD_WRITE_BYTE = 3'h3;
  localparam logic [2:0] CMD_READ_BYTE  = 3'h4;
  localparam logic [2:0] CMD_ERASE      = 3'h5;
  typedef enum logic [3:0] {
    ST_SYNC1 = 4'b0001,
    ST_SYNC2 = 4'b0010,
    ST_LOAD  = 4'b0100,
    ST_RUN   = 4'b1000
  } boot_state_t;
endpackage

/* boot_map_and_lock_control.sv */
`timescale 1ns/1ps
// Contract
// - all lock bits erased gives level zero, nothing restricted
// - level one refuses hardware programming of user and boot memory
// - level two also refuses hardware read-back verification
// - level three also blocks external code execution
// - level decoded by priority lock bit two, one, zero; internal paths open
// - boot enable maps boot memory at F000h-FFFFh; clear unmaps it
// - software write of aux register sets or clears boot enable
// - boot request pin low at reset sets enable, vector F000h
// - programmed jump bit sets enable at reset, vector F000h
// - aux bit two reads zero, ignores writes; increment toggles select
// - aux bit zero selects first or second data pointer
// - aux bit three is a plain software flag
// - aux bits three, two, zero are zero after reset
// - reset loads double speed mode from security byte bit seven
// - lock bits two to zero programmable only in hardware mode
// - security byte bits five to three always read unprogrammed
// - chip erase leaves every security byte bit erased, speed and jump bits too
// - boot vector byte stores start address high byte, erased by erase; boot start stays F000h, the byte is only read back
// - software security byte stores eight bits, erased by erase
// - twelve oscillator periods per cycle standard, six double speed
module boot_map_and_lock_control
  import boot_lock_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        nv_rst_n_i,
  input  wire logic        boot_request_pin_n_i,
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic        sfr_rd_i,
  input  wire logic [7:0]  sfr_wdata_i,
  output logic      [7:0]  sfr_rdata_o,
  input  wire logic [15:0] code_addr_i,
  output logic             boot_space_sel_o,
  input  wire logic        sw_nv_wr_i,
  input  wire logic [1:0]  sw_nv_sel_i,
  input  wire logic [7:0]  sw_nv_data_i,
  input  wire logic        hw_mode_i,
  input  wire logic        hw_cmd_valid_i,
  input  wire logic [2:0]  hw_cmd_i,
  input  wire logic [1:0]  hw_sel_i,
  input  wire logic [7:0]  hw_data_i,
  output logic             hw_grant_o,
  output logic             hw_deny_o,
  output logic      [7:0]  hw_rdata_o,
  output logic      [1:0]  lock_level_o,
  output logic             hw_prog_allow_o,
  output logic             hw_verify_allow_o,
  output logic             ext_exec_allow_o,
  output logic             core_hold_o,
  output logic      [15:0] reset_vector_o,
  output logic             boot_map_enable_o,
  output logic             pointer_select_o,
  output logic             user_flag_o,
  output logic      [15:0] data_pointer_o,
  output logic             double_speed_mode_o,
  output logic      [3:0]  cycles_per_machine_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  boot_state_t state_reg, state_next;
  logic        sync1_reg, sync2_reg;
  logic [7:0]  hsb_reg, hsb_next, sbv_reg, sbv_next, ssb_reg, ssb_next;
  logic        boot_reg, boot_next, dps_reg, dps_next, flag_reg, flag_next;
  logic [15:0] dp_first_reg, dp_first_next, dp_second_reg, dp_second_next;
  logic [15:0] vector_reg, vector_next, dp_out_reg, dp_out_next;
  logic [7:0]  rdata_reg, rdata_next, hw_rdata_reg, hw_rdata_next;
  logic        hold_reg, hold_next, x2_reg, x2_next, sel_reg, sel_next;
  logic        grant_reg, grant_next, deny_reg, deny_next;
  logic [1:0]  level_reg, level_next;
  logic        prog_ok_reg, prog_ok_next, ver_ok_reg, ver_ok_next;
  logic        ext_ok_reg, ext_ok_next;
  logic [3:0]  cyc_reg, cyc_next;
  logic [7:0]  hsb_view;
  logic [15:0] dp_sel;
  logic        hw_take;

  // ---------------------------------------------------------------
  // nonvolatile bytes
  // ---------------------------------------------------------------
  // kept on a power-on reset of their own so chip reset never erases
  always_comb
  begin
    hsb_next = hsb_reg;
    sbv_next = sbv_reg;
    ssb_next = ssb_reg;
    hw_take  = hw_mode_i && hw_cmd_valid_i;
    if (hw_take && hw_cmd_i == CMD_ERASE)
    begin
      hsb_next = ERASED_BYTE;
      sbv_next = ERASED_BYTE;
      ssb_next = ERASED_BYTE;
    end
    else if (hw_take && hw_cmd_i == CMD_WRITE_BYTE)
    begin
      // flash cells only program towards zero
      case (hw_sel_i)
        SEL_HSB: hsb_next = (hsb_reg & hw_data_i) | HSB_RSV_MASK;
        SEL_SBV: sbv_next = sbv_reg & hw_data_i;
        SEL_SSB: ssb_next = ssb_reg & hw_data_i;
        default: hsb_next = hsb_reg;
      endcase
    end
    else if (sw_nv_wr_i)
    begin
      case (sw_nv_sel_i)
        SEL_HSB: hsb_next = hsb_reg & (sw_nv_data_i | ~HSB_SW_MASK);
        SEL_SBV: sbv_next = sbv_reg & sw_nv_data_i;
        SEL_SSB: ssb_next = ssb_reg & sw_nv_data_i;
        default: hsb_next = hsb_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge nv_rst_n_i)
  begin
    if (!nv_rst_n_i)
    begin
      hsb_reg <= ERASED_BYTE;
      sbv_reg <= ERASED_BYTE;
      ssb_reg <= ERASED_BYTE;
    end
    else
    begin
      hsb_reg <= hsb_next;
      sbv_reg <= sbv_next;
      ssb_reg <= ssb_next;
    end
  end

  // ---------------------------------------------------------------
  // reset sequence, registers and protection
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next     = state_reg;
    boot_next      = boot_reg;
    vector_next    = vector_reg;
    x2_next        = x2_reg;
    dps_next       = dps_reg;
    flag_next      = flag_reg;
    dp_first_next  = dp_first_reg;
    dp_second_next = dp_second_reg;
    rdata_next     = rdata_reg;
    hw_rdata_next  = hw_rdata_reg;
    grant_next     = 1'b0;
    deny_next      = 1'b0;
    hsb_view       = hsb_reg | HSB_RSV_MASK;
    dp_sel         = dps_reg ? dp_second_reg : dp_first_reg;
    case (state_reg)
      ST_SYNC1: state_next = ST_SYNC2;
      ST_SYNC2: state_next = ST_LOAD;
      ST_LOAD:
      begin
        state_next = ST_RUN;
        // pin low or jump bit programmed maps boot memory
        boot_next = !sync2_reg || !hsb_reg[HSB_JUMP_BIT];
        vector_next = boot_next ? BOOT_BASE : USER_VECTOR;
        x2_next = !hsb_reg[HSB_SPEED_BIT];
      end
      ST_RUN:
      begin
        if (sfr_wr_i && sfr_addr_i == AUX_ADDR)
        begin
          boot_next = sfr_wdata_i[AUX_BOOT_BIT];
          dps_next  = sfr_wdata_i[AUX_DPS_BIT];
          flag_next = sfr_wdata_i[AUX_FLAG_BIT];
        end
        if (sfr_wr_i && sfr_addr_i == DPH_ADDR)
        begin
          if (dps_reg)
            dp_second_next[15:8] = sfr_wdata_i;
          else
            dp_first_next[15:8] = sfr_wdata_i;
        end
        if (sfr_wr_i && sfr_addr_i == DPL_ADDR)
        begin
          if (dps_reg)
            dp_second_next[7:0] = sfr_wdata_i;
          else
            dp_first_next[7:0] = sfr_wdata_i;
        end
      end
      default: state_next = ST_SYNC1;
    endcase
    if (sfr_rd_i)
    begin
      case (sfr_addr_i)
        // reserved and stuck bits read zero
        AUX_ADDR: rdata_next = {2'h0, boot_reg, 1'b0, flag_reg, 2'h0,
                                dps_reg};
        DPH_ADDR: rdata_next = dp_sel[15:8];
        DPL_ADDR: rdata_next = dp_sel[7:0];
        default:  rdata_next = ZERO_BYTE;
      endcase
    end
    // lock bits programmed means zero
    if (!hsb_reg[HSB_LB2_BIT])
      level_next = LEVEL_3;
    else if (!hsb_reg[HSB_LB1_BIT])
      level_next = LEVEL_2;
    else if (!hsb_reg[HSB_LB0_BIT])
      level_next = LEVEL_1;
    else
      level_next = LEVEL_0;
    // permissions registered with the level so they never lag it
    prog_ok_next = (level_next == LEVEL_0);
    ver_ok_next  = (level_next < LEVEL_2);
    ext_ok_next  = (level_next != LEVEL_3);
    cyc_next     = x2_next ? CYC_X2 : CYC_STD;
    if (hw_take)
    begin
      case (hw_cmd_i)
        CMD_PROG_MEM:
        begin
          grant_next = (level_reg == LEVEL_0);
          deny_next  = (level_reg != LEVEL_0);
        end
        CMD_VERIFY_MEM:
        begin
          grant_next = (level_reg < LEVEL_2);
          deny_next  = (level_reg >= LEVEL_2);
        end
        CMD_READ_BYTE:
        begin
          grant_next = 1'b1;
          case (hw_sel_i)
            SEL_HSB: hw_rdata_next = hsb_view;
            SEL_SBV: hw_rdata_next = sbv_reg;
            SEL_SSB: hw_rdata_next = ssb_reg;
            default: hw_rdata_next = ZERO_BYTE;
          endcase
        end
        CMD_WRITE_BYTE, CMD_ERASE: grant_next = 1'b1;
        default: deny_next = 1'b1;
      endcase
    end
    hold_next   = (state_next != ST_RUN);
    sel_next    = boot_reg && (code_addr_i >= BOOT_BASE);
    dp_out_next = dps_next ? dp_second_next : dp_first_next;
  end

  // two flops ahead of any use of the pin
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg     <= ST_SYNC1;
      sync1_reg     <= 1'b1;
      sync2_reg     <= 1'b1;
      boot_reg      <= 1'b0;
      vector_reg    <= USER_VECTOR;
      x2_reg        <= 1'b0;
      dps_reg       <= 1'b0;
      flag_reg      <= 1'b0;
      dp_first_reg  <= ZERO_WORD;
      dp_second_reg <= ZERO_WORD;
      dp_out_reg    <= ZERO_WORD;
      rdata_reg     <= ZERO_BYTE;
      hw_rdata_reg  <= ZERO_BYTE;
      grant_reg     <= 1'b0;
      deny_reg      <= 1'b0;
      level_reg     <= LEVEL_0;
      prog_ok_reg   <= 1'b1;
      ver_ok_reg    <= 1'b1;
      ext_ok_reg    <= 1'b1;
      cyc_reg       <= CYC_STD;
      hold_reg      <= 1'b1;
      sel_reg       <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      sync1_reg     <= boot_request_pin_n_i;
      sync2_reg     <= sync1_reg;
      boot_reg      <= boot_next;
      vector_reg    <= vector_next;
      x2_reg        <= x2_next;
      dps_reg       <= dps_next;
      flag_reg      <= flag_next;
      dp_first_reg  <= dp_first_next;
      dp_second_reg <= dp_second_next;
      dp_out_reg    <= dp_out_next;
      rdata_reg     <= rdata_next;
      hw_rdata_reg  <= hw_rdata_next;
      grant_reg     <= grant_next;
      deny_reg      <= deny_next;
      level_reg     <= level_next;
      prog_ok_reg   <= prog_ok_next;
      ver_ok_reg    <= ver_ok_next;
      ext_ok_reg    <= ext_ok_next;
      cyc_reg       <= cyc_next;
      hold_reg      <= hold_next;
      sel_reg       <= sel_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // level lags the lock bits by one edge; tool must wait one cycle
  assign sfr_rdata_o          = rdata_reg;
  assign boot_space_sel_o     = sel_reg;
  assign hw_grant_o           = grant_reg;
  assign hw_deny_o            = deny_reg;
  assign hw_rdata_o           = hw_rdata_reg;
  assign lock_level_o         = level_reg;
  assign hw_prog_allow_o      = prog_ok_reg;
  assign hw_verify_allow_o    = ver_ok_reg;
  assign ext_exec_allow_o     = ext_ok_reg;
  assign core_hold_o          = hold_reg;
  assign reset_vector_o       = vector_reg;
  assign boot_map_enable_o    = boot_reg;
  assign pointer_select_o     = dps_reg;
  assign user_flag_o          = flag_reg;
  assign data_pointer_o       = dp_out_reg;
  assign double_speed_mode_o  = x2_reg;
  assign cycles_per_machine_o = cyc_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_erased_level;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (hsb_reg[2:0] == 3'h7) ##1 (hsb_reg[2:0] == 3'h7)
      |-> (lock_level_o == LEVEL_0) && ext_exec_allow_o;
  endproperty
  a_erased_level: assert property (p_erased_level)
    else $error("erased lock bits not level zero");

  property p_prog_refused;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (hw_take && hw_cmd_i == CMD_PROG_MEM && level_reg != LEVEL_0)
      |=> hw_deny_o && !hw_grant_o;
  endproperty
  a_prog_refused: assert property (p_prog_refused)
    else $error("programming granted while locked");

  property p_verify_refused;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (hw_take && hw_cmd_i == CMD_VERIFY_MEM && level_reg >= LEVEL_2)
      |=> hw_deny_o && !hw_grant_o;
  endproperty
  a_verify_refused: assert property (p_verify_refused)
    else $error("verify granted at level two or above");

  property p_top_level;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(hsb_reg[HSB_LB2_BIT])
      |=> (lock_level_o == LEVEL_3) && !ext_exec_allow_o;
  endproperty
  a_top_level: assert property (p_top_level)
    else $error("lock bit two did not give level three");

  property p_pin_boot;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (state_reg == ST_LOAD && !sync2_reg)
      |=> boot_map_enable_o && reset_vector_o == BOOT_BASE && !core_hold_o;
  endproperty
  a_pin_boot: assert property (p_pin_boot)
    else $error("boot request pin ignored at reset");

  property p_jump_boot;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (state_reg == ST_LOAD && !hsb_reg[HSB_JUMP_BIT])
      |=> boot_map_enable_o && reset_vector_o == BOOT_BASE;
  endproperty
  a_jump_boot: assert property (p_jump_boot)
    else $error("jump bit ignored at reset");

  property p_user_start;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (state_reg == ST_LOAD && sync2_reg && hsb_reg[HSB_JUMP_BIT])
      |=> !boot_map_enable_o && reset_vector_o == USER_VECTOR;
  endproperty
  a_user_start: assert property (p_user_start)
    else $error("boot mapped without request");

  property p_boot_map;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    boot_map_enable_o ##1 boot_map_enable_o && code_addr_i < BOOT_BASE
      |=> !boot_space_sel_o;
  endproperty
  a_boot_map: assert property (p_boot_map)
    else $error("boot space selected below its base");

  property p_aux_zero;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (sfr_rd_i && sfr_addr_i == AUX_ADDR)
      |=> sfr_rdata_o[2] == 1'b0 && sfr_rdata_o[0] == pointer_select_o;
  endproperty
  a_aux_zero: assert property (p_aux_zero)
    else $error("aux read wrong");

  property p_speed_load;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (state_reg == ST_LOAD)
      |=> double_speed_mode_o == !$past(hsb_reg[HSB_SPEED_BIT])
          && cycles_per_machine_o == (double_speed_mode_o ? 4'h6 : 4'hc);
  endproperty
  a_speed_load: assert property (p_speed_load)
    else $error("speed mode not loaded from security byte");
endmodule

/* boot_map_and_lock_control_bench.sv */
`timescale 1ns/1ps
module boot_map_and_lock_control_bench
  import boot_lock_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic        nv_rst_n;
  logic        pin_n;
  logic [7:0]  sfr_addr;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic [15:0] code_addr;
  logic        boot_sel;
  logic        sw_wr;
  logic [1:0]  sw_sel;
  logic [7:0]  sw_data;
  logic        hw_mode;
  logic        hw_valid;
  logic [2:0]  hw_cmd;
  logic [1:0]  hw_sel;
  logic [7:0]  hw_data;
  logic        hw_grant;
  logic        hw_deny;
  logic [7:0]  hw_rdata;
  logic [1:0]  lock_lvl;
  logic        prog_ok;
  logic        ver_ok;
  logic        ext_ok;
  logic        hold;
  logic [15:0] rvec;
  logic        boot_en;
  logic        pointer_select;
  logic        flag;
  logic [15:0] dptr;
  logic        dbl;
  logic [3:0]  cyc;
  int          fails;
  int          num_checks;
  int          cycles;
  logic [7:0]  lock_val [3] = '{8'hfe, 8'hfd, 8'hfb};
  logic [2:0]  allow_exp [3] = '{3'b011, 3'b001, 3'b000};
  logic [1:0]  ver_exp [3] = '{2'b10, 2'b01, 2'b01};

  boot_map_and_lock_control u_dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .nv_rst_n_i(nv_rst_n),
    .boot_request_pin_n_i(pin_n), .sfr_addr_i(sfr_addr),
    .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd), .sfr_wdata_i(sfr_wdata),
    .sfr_rdata_o(sfr_rdata), .code_addr_i(code_addr),
    .boot_space_sel_o(boot_sel), .sw_nv_wr_i(sw_wr),
    .sw_nv_sel_i(sw_sel), .sw_nv_data_i(sw_data), .hw_mode_i(hw_mode),
    .hw_cmd_valid_i(hw_valid), .hw_cmd_i(hw_cmd), .hw_sel_i(hw_sel),
    .hw_data_i(hw_data), .hw_grant_o(hw_grant), .hw_deny_o(hw_deny),
    .hw_rdata_o(hw_rdata), .lock_level_o(lock_lvl),
    .hw_prog_allow_o(prog_ok), .hw_verify_allow_o(ver_ok),
    .ext_exec_allow_o(ext_ok), .core_hold_o(hold),
    .reset_vector_o(rvec), .boot_map_enable_o(boot_en),
    .pointer_select_o(pointer_select), .user_flag_o(flag),
    .data_pointer_o(dptr), .double_speed_mode_o(dbl),
    .cycles_per_machine_o(cyc)
  );

  prog_tool_model u_tool (
    .core_clk_i(clk), .hw_grant_i(hw_grant), .hw_deny_i(hw_deny),
    .hw_rdata_i(hw_rdata), .hw_mode_o(hw_mode),
    .hw_cmd_valid_o(hw_valid), .hw_cmd_o(hw_cmd), .hw_sel_o(hw_sel),
    .hw_data_o(hw_data)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // --------------------------
  // shared tasks
  // --------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // generous ceiling; the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      $display("MISMATCH at %0t: run hung", $time);
      wrap_up();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic do_reset(input logic pin_lvl);
    int n;
    @(negedge clk);
    rst_n = 1'b0;
    pin_n = pin_lvl;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    n = 0;
    while (hold !== 1'b0 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    check(hold, 1'b0, "hold released");
    @(negedge clk);
    pin_n = 1'b1;
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask

  task automatic sw_nv(input logic [1:0] s, input logic [7:0] d);
    @(negedge clk);
    sw_sel = s;
    sw_data = d;
    sw_wr = 1'b1;
    @(negedge clk);
    sw_wr = 1'b0;
  endtask

  task automatic hw(input logic [2:0] c, input logic [1:0] s,
                    input logic [7:0] d, input logic [1:0] exp_gd,
                    output logic [7:0] r);
    logic g;
    logic n;
    u_tool.send(1'b1, c, s, d, g, n, r);
    check({g, n}, exp_gd, "hw answer");
  endtask

  task automatic fetch(input logic [15:0] a, input logic exp);
    @(negedge clk);
    code_addr = a;
    @(negedge clk);
    check(boot_sel, exp, "boot select");
  endtask

  // --------------------------
  // scenarios
  // --------------------------
  task automatic t_defaults();
    logic [7:0] r;
    check(lock_lvl, LEVEL_0, "level");
    check({prog_ok, ver_ok, ext_ok}, 3'b111, "allows");
    check({boot_en, rvec}, {1'b0, USER_VECTOR}, "vector");
    check({dbl, cyc}, {1'b0, CYC_STD}, "speed");
    sfr_read(AUX_ADDR, r);
    check(r & 8'h0d, 8'h00, "aux reset");
    sfr_read(8'ha3, r);
    check(r, ZERO_BYTE, "unmapped");
  endtask

  task automatic t_aux();
    logic [7:0] r;
    sfr_write(AUX_ADDR, 8'h2d);
    sfr_read(AUX_ADDR, r);
    check(r, 8'h29, "aux write");
    check({boot_en, flag, pointer_select}, 3'b111, "aux fields");
    sfr_write(DPH_ADDR, 8'h12);
    sfr_write(DPL_ADDR, 8'h34);
    check(dptr, 16'h1234, "pointer two");
    sfr_write(AUX_ADDR, r + 8'h01);
    sfr_read(AUX_ADDR, r);
    check(r, 8'h28, "aux increment");
    check({flag, pointer_select}, 2'b10, "flag kept");
    check(dptr, ZERO_WORD, "pointer one");
  endtask

  task automatic t_map();
    fetch(16'hefff, 1'b0);
    fetch(BOOT_BASE, 1'b1);
    fetch(16'hffff, 1'b1);
    sfr_write(AUX_ADDR, 8'h08);
    fetch(BOOT_BASE, 1'b0);
  endtask

  task automatic t_nvbytes();
    logic [7:0] r;
    hw(CMD_WRITE_BYTE, SEL_SBV, 8'h5a, 2'b10, r);
    hw(CMD_READ_BYTE, SEL_SBV, 8'h00, 2'b10, r);
    check(r, 8'h5a, "vector byte");
    sw_nv(SEL_SSB, 8'ha5);
    hw(CMD_READ_BYTE, SEL_SSB, 8'h00, 2'b10, r);
    check(r, 8'ha5, "soft security");
    hw(CMD_ERASE, SEL_HSB, 8'hff, 2'b10, r);
    for (int i = 0; i < 3; i++)
    begin
      hw(CMD_READ_BYTE, i[1:0], 8'h00, 2'b10, r);
      check(r, ERASED_BYTE, "erased");
    end
  endtask

  task automatic t_levels();
    logic [7:0] r;
    logic       g;
    logic       n;
    hw(CMD_PROG_MEM, SEL_HSB, 8'h00, 2'b10, r);
    hw(CMD_VERIFY_MEM, SEL_HSB, 8'h00, 2'b10, r);
    hw(3'h7, SEL_HSB, 8'h00, 2'b01, r);
    for (int i = 0; i < 3; i++)
    begin
      hw(CMD_ERASE, SEL_HSB, 8'hff, 2'b10, r);
      hw(CMD_WRITE_BYTE, SEL_HSB, lock_val[i], 2'b10, r);
      @(negedge clk);
      check(lock_lvl, i[1:0] + 2'd1, "level");
      check({prog_ok, ver_ok, ext_ok}, allow_exp[i], "allows");
      hw(CMD_PROG_MEM, SEL_HSB, 8'h00, 2'b01, r);
      hw(CMD_VERIFY_MEM, SEL_HSB, 8'h00, ver_exp[i], r);
    end
    hw(CMD_READ_BYTE, SEL_HSB, 8'h00, 2'b10, r);
    check(r, 8'hfb, "lock byte");
    u_tool.send(1'b0, CMD_ERASE, SEL_HSB, 8'hff, g, n, r);
    check({g, n}, 2'b00, "mode off");
    check(lock_lvl, LEVEL_3, "level kept");
  endtask

  task automatic t_boot_jump();
    logic [7:0] r;
    sw_nv(SEL_HSB, 8'h30);
    hw(CMD_READ_BYTE, SEL_HSB, 8'h00, 2'b10, r);
    check(r, 8'h3b, "soft write");
    do_reset(1'b1);
    check({boot_en, rvec}, {1'b1, BOOT_BASE}, "jump");
    check({dbl, cyc}, {1'b1, CYC_X2}, "double");
    check(lock_lvl, LEVEL_3, "level");
    fetch(16'hf800, 1'b1);
  endtask

  task automatic t_pin();
    logic [7:0] r;
    hw(CMD_ERASE, SEL_HSB, 8'hff, 2'b10, r);
    do_reset(1'b0);
    check({boot_en, rvec}, {1'b1, BOOT_BASE}, "pin");
    check({dbl, cyc}, {1'b0, CYC_STD}, "standard");
    do_reset(1'b1);
    check({boot_en, rvec}, {1'b0, USER_VECTOR}, "no boot");
  endtask

  initial
  begin
    fails = 0;
    num_checks = 0;
    cycles = 0;
    rst_n = 1'b0;
    nv_rst_n = 1'b0;
    pin_n = 1'b1;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    code_addr = 16'h0000;
    sw_wr = 1'b0;
    sw_sel = 2'h0;
    sw_data = 8'h00;
    @(negedge clk);
    nv_rst_n = 1'b1;
    do_reset(1'b1);
    t_defaults();
    t_aux();
    t_map();
    t_nvbytes();
    t_levels();
    t_boot_jump();
    t_pin();
    wrap_up();
  end
endmodule

/* prog_tool_model.sv */
`timescale 1ns/1ps
module prog_tool_model
  import boot_lock_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       hw_grant_i,
  input  wire logic       hw_deny_i,
  input  wire logic [7:0] hw_rdata_i,
  output logic            hw_mode_o,
  output logic            hw_cmd_valid_o,
  output logic      [2:0] hw_cmd_o,
  output logic      [1:0] hw_sel_o,
  output logic      [7:0] hw_data_o
);
  // --------------------------
  // parallel programmer
  // --------------------------
  initial
  begin
    hw_mode_o = 1'b0;
    hw_cmd_valid_o = 1'b0;
    hw_cmd_o = 3'h0;
    hw_sel_o = 2'h0;
    hw_data_o = 8'h00;
  end
  // mode stays as last set; answer sampled at the negedge half a cycle after taking
  task automatic send(input logic m, input logic [2:0] c,
                      input logic [1:0] s, input logic [7:0] d,
                      output logic g, output logic n,
                      output logic [7:0] r);
    @(negedge core_clk_i);
    hw_mode_o = m;
    hw_cmd_valid_o = 1'b1;
    hw_cmd_o = c;
    hw_sel_o = s;
    hw_data_o = (s == SEL_HSB) ? (d | HSB_RSV_MASK) : d;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    g = hw_grant_i;
    n = hw_deny_i;
    r = hw_rdata_i;
    hw_cmd_valid_o = 1'b0;
    // released lines flip so stale data is never mistaken
    hw_cmd_o = ~c;
    hw_sel_o = ~s;
    hw_data_o = ~d;
  endtask
endmodule
